// ===== acc_consts.svh
// Register map, reset values, command and fault codes and timing of the accel bank.
// Assumes it is included once by name into files that need the figures.
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
`define ACC_A_ID      8'h00
`define ACC_A_ERR     8'h02
`define ACC_A_STAT    8'h03
`define ACC_A_XL      8'h12
`define ACC_A_XH      8'h13
`define ACC_A_YL      8'h14
`define ACC_A_YH      8'h15
`define ACC_A_ZL      8'h16
`define ACC_A_ZH      8'h17
`define ACC_A_T0      8'h18
`define ACC_A_T1      8'h19
`define ACC_A_T2      8'h1a
`define ACC_A_INT     8'h1d
`define ACC_A_TH      8'h22
`define ACC_A_TL      8'h23
`define ACC_A_CONF    8'h40
`define ACC_A_RANGE   8'h41
`define ACC_A_IO1     8'h53
`define ACC_A_IO2     8'h54
`define ACC_A_MAP     8'h58
`define ACC_A_SELF    8'h6d
`define ACC_A_PCONF   8'h7c
`define ACC_A_PCTRL   8'h7d
`define ACC_A_SRST    8'h7e
`define ACC_RST_CONF  8'ha8
`define ACC_RST_RANGE 2'h1
`define ACC_RST_PCONF 8'h03
`define ACC_STAT_FIX  8'h10
`define ACC_SRST_CMD  8'hb6
`define ACC_ERR_CONF  3'h1
`define ACC_CLK_MHZ   10
`define ACC_TICK_US   39.0625
`define ACC_TICK_FRAC 16
`define ACC_TEMP_S    1.28
`endif

// ===== acc_pkg.sv
// Types shared by the accel register bank files.
// Assumes nothing of its surroundings.
package acc_pkg;
	typedef enum logic [1:0] {SP_IDLE, SP_ADDR, SP_DATA} acc_spi_st_t;
	typedef struct packed {
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] z;
	} acc_axes_t;
	typedef struct packed {
		logic in_en;
		logic out_en;
		logic od;
		logic lvl;
	} acc_pin_cfg_t;
endpackage : acc_pkg

// ===== acc_sync2.sv
// Two-flop synchroniser for pin inputs.
// Assumes i_d is asynchronous to i_clk.
module acc_sync2 #(
	parameter int       W   = 1,
	parameter logic [W-1:0] RST = '0
)(
	input  wire logic         i_clk,
	input  wire logic         i_rst_b,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			meta_r <= RST;
			o_q    <= RST;
		end
		else
		begin
			meta_r <= i_d;
			o_q    <= meta_r;
		end
	end
endmodule : acc_sync2

// ===== acc_axis_lock.sv
// One axis result: low and high byte with high-byte freeze after a low read.
// Assumes load and read strobes are one-cycle pulses on i_clk.
module acc_axis_lock (
	input  wire logic        i_clk,
	input  wire logic        i_clr,
	input  wire logic        i_load,
	input  wire logic [15:0] i_sample,
	input  wire logic        i_rd_low,
	input  wire logic        i_rd_high,
	output logic      [7:0]  o_low,
	output logic      [7:0]  o_high
);
	logic       lock_r;
	logic [7:0] hold_r;
	wire logic lock_nxt = i_rd_low | (lock_r & ~i_rd_high);

	always_ff @(posedge i_clk)
	begin
		if (i_clr)
		begin
			lock_r <= 1'b0;
			hold_r <= 8'h00;
			o_low  <= 8'h00;
			o_high <= 8'h00;
		end
		else
		begin
			lock_r <= lock_nxt;
			if (i_load)
			begin
				o_low  <= i_sample[7:0];
				hold_r <= i_sample[15:8];
			end
			// A sample taken while frozen is shown once the freeze ends.
			if (!lock_nxt && !lock_r)
				o_high <= i_load ? i_sample[15:8] : hold_r;
		end
	end

	lock_hold_a: assert property (@(posedge i_clk) disable iff (i_clr)
		lock_r && !i_rd_high |=> $stable(o_high))
		else $error("High byte changed while frozen.");
endmodule : acc_axis_lock

// ===== acc_register_bank.sv
// Accelerometer register bank behind a four-wire serial port, mode 0.
// Assumes sample, temperature and fault inputs come from i_clk logic.
`include "acc_consts.svh"
module acc_register_bank
	import acc_pkg::*;
#(
	parameter logic [7:0] ID_CODE  = 8'h5a, // Arbitrary value.
	parameter int         TEMP_CYC =
		int'(`ACC_TEMP_S * 1.0e6 * `ACC_CLK_MHZ)
)(
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_spi_sck,
	input  wire logic        i_spi_cs_b,
	input  wire logic        i_spi_mosi,
	output logic             o_spi_miso,
	output logic             o_spi_miso_oe,
	input  wire logic        i_sample_valid,
	input  wire acc_axes_t   i_sample,
	input  wire logic [10:0] i_temp_value,
	input  wire logic        i_fatal_fault,
	output logic             o_irq_pin_one,
	output logic             o_irq_pin_one_oe,
	output logic             o_irq_pin_two,
	output logic             o_irq_pin_two_oe
);
	localparam int TICK_SUM =
		int'(`ACC_TICK_US * `ACC_CLK_MHZ * `ACC_TICK_FRAC);

	logic         sck_s;
	logic         cs_b_s;
	logic         mosi_s;
	logic         sck_d_r;
	acc_spi_st_t  st_r;
	logic [2:0]   bit_r;
	logic [7:0]   rx_r;
	logic [7:0]   tx_r;
	logic [7:0]   addr_r;
	logic         rw_r;
	logic         srst_pend_r;
	logic         soft_r;
	logic         fatal_r;
	logic         drdy_r;
	logic         intf_r;
	logic [7:0]   conf_r;
	logic [1:0]   range_r;
	acc_pin_cfg_t pin_cfg_r [2];
	logic [1:0]   map_r;
	logic [7:0]   self_r;
	logic [7:0]   pconf_r;
	logic [7:0]   pctrl_r;
	logic [12:0]  frac_r;
	logic [23:0]  time_r;
	logic [23:0]  temp_cnt_r;
	logic [10:0]  temp_r;
	logic [1:0]   pin_out_r;
	logic [1:0]   pin_oe_r;
	logic [8:0]   gap_r;
	logic [15:0]  axis_in [3];
	logic [7:0]   axis_lo [3];
	logic [7:0]   axis_hi [3];

	acc_sync2 #(.W(3), .RST(3'b010)) u_sync (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_d     ({i_spi_sck, i_spi_cs_b, i_spi_mosi}),
		.o_q     ({sck_s, cs_b_s, mosi_s})
	);

	// Serial framing decode.
	wire logic       clr      = ~i_rst_b | soft_r;
	wire logic       rise     = sck_s & ~sck_d_r & ~cs_b_s;
	wire logic       fall     = ~sck_s & sck_d_r & ~cs_b_s;
	wire logic [7:0] rx_nxt   = {rx_r[6:0], mosi_s};
	wire logic       byte_end = rise & (bit_r == 3'h7);
	wire logic       in_addr  = (st_r == SP_ADDR);
	wire logic       in_data  = (st_r == SP_DATA);
	wire logic       rd_go    = byte_end & (in_addr ? rx_nxt[7] : rw_r);
	wire logic       wr_go    = byte_end & in_data & ~rw_r;
	wire logic [7:0] rd_addr  =
		in_addr ? {1'b0, rx_nxt[6:0]} : addr_r;
	wire logic [7:0] wr_addr  = addr_r;

	// Write decode.
	wire logic wr_conf  = wr_go & (wr_addr == `ACC_A_CONF);
	wire logic wr_range = wr_go & (wr_addr == `ACC_A_RANGE);
	wire logic wr_io1   = wr_go & (wr_addr == `ACC_A_IO1);
	wire logic wr_io2   = wr_go & (wr_addr == `ACC_A_IO2);
	wire logic wr_map   = wr_go & (wr_addr == `ACC_A_MAP);
	wire logic wr_self  = wr_go & (wr_addr == `ACC_A_SELF);
	wire logic wr_pconf = wr_go & (wr_addr == `ACC_A_PCONF);
	wire logic wr_pctrl = wr_go & (wr_addr == `ACC_A_PCTRL);
	wire logic wr_srst  = wr_go & (wr_addr == `ACC_A_SRST)
		& (rx_nxt == `ACC_SRST_CMD);

	// Read side effects.
	wire logic rd_data = rd_go & (rd_addr >= `ACC_A_XL)
		& (rd_addr <= `ACC_A_ZH);
	wire logic rd_int  = rd_go & (rd_addr == `ACC_A_INT);

	// Fault code from an unsupported filter or rate setting.
	wire logic conf_bad = (conf_r[7:4] < 4'h8) | (conf_r[7:4] > 4'ha)
		| (conf_r[3:0] < 4'h5) | (conf_r[3:0] > 4'hc);
	wire logic [2:0] err_code = conf_bad ? `ACC_ERR_CONF : 3'h0;

	wire logic [12:0] frac_sum = frac_r + 13'(`ACC_TICK_FRAC);
	wire logic        tick     = (frac_sum >= 13'(TICK_SUM));
	wire logic        temp_upd = (temp_cnt_r == 24'(TEMP_CYC - 1));

	// Read data; unmapped and reserved positions give zero.
	wire logic [7:0] rd_byte =
		(rd_addr == `ACC_A_ID)    ? ID_CODE :
		(rd_addr == `ACC_A_ERR)   ? {3'h0, err_code, 1'b0, fatal_r} :
		(rd_addr == `ACC_A_STAT)  ? ({drdy_r, 7'h00} | `ACC_STAT_FIX) :
		(rd_addr == `ACC_A_XL)    ? axis_lo[0] :
		(rd_addr == `ACC_A_XH)    ? axis_hi[0] :
		(rd_addr == `ACC_A_YL)    ? axis_lo[1] :
		(rd_addr == `ACC_A_YH)    ? axis_hi[1] :
		(rd_addr == `ACC_A_ZL)    ? axis_lo[2] :
		(rd_addr == `ACC_A_ZH)    ? axis_hi[2] :
		(rd_addr == `ACC_A_T0)    ? time_r[7:0] :
		(rd_addr == `ACC_A_T1)    ? time_r[15:8] :
		(rd_addr == `ACC_A_T2)    ? time_r[23:16] :
		(rd_addr == `ACC_A_INT)   ? {intf_r, 7'h00} :
		(rd_addr == `ACC_A_TH)    ? temp_r[10:3] :
		(rd_addr == `ACC_A_TL)    ? {temp_r[2:0], 5'h00} :
		(rd_addr == `ACC_A_CONF)  ? conf_r :
		(rd_addr == `ACC_A_RANGE) ? {6'h00, range_r} :
		(rd_addr == `ACC_A_IO1)   ? {3'h0, pin_cfg_r[0], 1'b0} :
		(rd_addr == `ACC_A_IO2)   ? {3'h0, pin_cfg_r[1], 1'b0} :
		(rd_addr == `ACC_A_MAP)   ? {1'b0, map_r[1], 3'h0, map_r[0], 2'h0} :
		(rd_addr == `ACC_A_SELF)  ? self_r :
		(rd_addr == `ACC_A_PCONF) ? pconf_r :
		(rd_addr == `ACC_A_PCTRL) ? pctrl_r : 8'h00;

	assign axis_in[0] = i_sample.x;
	assign axis_in[1] = i_sample.y;
	assign axis_in[2] = i_sample.z;

	for (genvar g = 0; g < 3; g++)
	begin : g_axis
		acc_axis_lock u_axis (
			.i_clk     (i_clk),
			.i_clr     (clr),
			.i_load    (i_sample_valid),
			.i_sample  (axis_in[g]),
			.i_rd_low  (rd_go & (rd_addr == 8'(`ACC_A_XL + 2 * g))),
			.i_rd_high (rd_go & (rd_addr == 8'(`ACC_A_XH + 2 * g))),
			.o_low     (axis_lo[g]),
			.o_high    (axis_hi[g])
		);
	end

	// Frame state; a raised select always ends the frame.
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b || cs_b_s)
		begin
			st_r  <= SP_IDLE;
			bit_r <= 3'h0;
		end
		else
		begin
			unique case (st_r)
				SP_IDLE: st_r <= SP_ADDR;
				SP_ADDR: if (byte_end) st_r <= SP_DATA;
				SP_DATA: st_r <= SP_DATA;
			endcase
			if (rise)
				bit_r <= bit_r + 3'h1;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			sck_d_r <= 1'b0;
			rx_r    <= 8'h00;
			addr_r  <= 8'h00;
			rw_r    <= 1'b0;
		end
		else
		begin
			sck_d_r <= sck_s;
			if (rise)
				rx_r <= rx_nxt;
			if (byte_end && in_addr)
				rw_r <= rx_nxt[7];
			if (rd_go)
				addr_r <= rd_addr + 8'h01;
			else if (byte_end && in_addr)
				addr_r <= {1'b0, rx_nxt[6:0]};
			else if (wr_go)
				addr_r <= addr_r + 8'h01;
		end
	end

	// Read data shift; each bit leaves on a falling serial clock edge.
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			tx_r          <= 8'h00;
			o_spi_miso    <= 1'b0;
			o_spi_miso_oe <= 1'b0;
		end
		else
		begin
			o_spi_miso_oe <= ~cs_b_s & in_data & rw_r;
			if (rd_go)
				tx_r <= rd_byte;
			else if (fall)
			begin
				o_spi_miso <= tx_r[7];
				tx_r       <= {tx_r[6:0], 1'b0};
			end
		end
	end

	// Soft reset waits for the end of the frame that carried it.
	always_ff @(posedge i_clk)
	begin
		if (clr)
			srst_pend_r <= 1'b0;
		else if (wr_srst)
			srst_pend_r <= 1'b1;
		soft_r <= i_rst_b & srst_pend_r & cs_b_s;
	end

	// Status flags; a new sample beats a clearing read.
	always_ff @(posedge i_clk)
	begin
		if (clr)
		begin
			fatal_r <= 1'b0;
			drdy_r  <= 1'b0;
			intf_r  <= 1'b0;
		end
		else
		begin
			fatal_r <= fatal_r | i_fatal_fault;
			drdy_r  <= i_sample_valid | (drdy_r & ~rd_data);
			intf_r  <= i_sample_valid | (intf_r & ~rd_int);
		end
	end

	// Configuration registers; reserved bits are never stored.
	always_ff @(posedge i_clk)
	begin
		if (clr)
		begin
			conf_r    <= `ACC_RST_CONF;
			range_r   <= `ACC_RST_RANGE;
			pin_cfg_r <= '{default: '0};
			map_r     <= 2'h0;
			self_r    <= 8'h00;
			pconf_r   <= `ACC_RST_PCONF;
			pctrl_r   <= 8'h00;
		end
		else
		begin
			if (wr_conf)  conf_r       <= rx_nxt;
			if (wr_range) range_r      <= rx_nxt[1:0];
			if (wr_io1)   pin_cfg_r[0] <= rx_nxt[4:1];
			if (wr_io2)   pin_cfg_r[1] <= rx_nxt[4:1];
			if (wr_map)   map_r        <= {rx_nxt[6], rx_nxt[2]};
			if (wr_self)  self_r       <= rx_nxt;
			if (wr_pconf) pconf_r      <= rx_nxt;
			if (wr_pctrl) pctrl_r      <= rx_nxt;
		end
	end

	// Time base: sixteen ticks per TICK_SUM cycles keeps the rate exact.
	always_ff @(posedge i_clk)
	begin
		if (clr)
		begin
			frac_r <= 13'h0;
			time_r <= 24'h0;
		end
		else
		begin
			frac_r <= tick ? frac_sum - 13'(TICK_SUM) : frac_sum;
			if (tick)
				time_r <= time_r + 24'h1;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (clr)
		begin
			temp_cnt_r <= 24'h0;
			temp_r     <= 11'h0;
		end
		else
		begin
			temp_cnt_r <= temp_upd ? 24'h0 : temp_cnt_r + 24'h1;
			if (temp_upd)
				temp_r <= i_temp_value;
		end
	end

	// Interrupt pins: level from polarity, open drain drives only low.
	wire logic [1:0] pin_pol = {pin_cfg_r[1].lvl, pin_cfg_r[0].lvl};
	wire logic [1:0] pin_drv = {pin_cfg_r[1].out_en, pin_cfg_r[0].out_en};
	wire logic [1:0] pin_od  = {pin_cfg_r[1].od, pin_cfg_r[0].od};
	wire logic [1:0] pin_act = {2{intf_r}} & map_r;
	wire logic [1:0] pin_lvl = pin_act ~^ pin_pol;

	always_ff @(posedge i_clk)
	begin
		if (clr)
		begin
			pin_out_r <= 2'h0;
			pin_oe_r  <= 2'h0;
		end
		else
		begin
			pin_out_r <= pin_lvl;
			pin_oe_r  <= pin_drv & ~(pin_od & pin_lvl);
		end
	end

	assign o_irq_pin_one    = pin_out_r[0];
	assign o_irq_pin_one_oe = pin_oe_r[0];
	assign o_irq_pin_two    = pin_out_r[1];
	assign o_irq_pin_two_oe = pin_oe_r[1];

	// Cycles since the last time tick, for checking only.
	always_ff @(posedge i_clk)
	begin
		if (clr || tick)
			gap_r <= 9'h0;
		else
			gap_r <= gap_r + 9'h1;
	end

	drdy_set_a: assert property (@(posedge i_clk) disable iff (clr)
		i_sample_valid |=> drdy_r && intf_r)
		else $error("Sample did not raise ready flags.");

	drdy_clr_a: assert property (@(posedge i_clk) disable iff (clr)
		rd_data && !i_sample_valid |=> !drdy_r)
		else $error("Data read did not clear ready status.");

	intf_clr_a: assert property (@(posedge i_clk) disable iff (clr)
		rd_int && !i_sample_valid |=> !intf_r ##1 !intf_r || $past(i_sample_valid))
		else $error("Interrupt flag read did not clear it.");

	tick_gap_a: assert property (@(posedge i_clk) disable iff (clr)
		tick |-> gap_r >= 9'h185 && gap_r <= 9'h186)
		else $error("Time tick spacing is wrong.");

	time_step_a: assert property (@(posedge i_clk) disable iff (clr)
		tick |=> time_r == $past(time_r) + 24'h1)
		else $error("Time counter did not step on tick.");

	fatal_keep_a: assert property (@(posedge i_clk) disable iff (clr)
		fatal_r |=> fatal_r)
		else $error("Fatal flag cleared without reset.");

	temp_take_a: assert property (@(posedge i_clk) disable iff (clr)
		temp_upd |=> temp_r == $past(i_temp_value) && temp_cnt_r == 24'h0)
		else $error("Temperature not refreshed at period end.");

	soft_rst_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		soft_r |=> conf_r == `ACC_RST_CONF && !drdy_r && time_r == 24'h0)
		else $error("Soft reset did not restore defaults.");

	err_code_a: assert property (@(posedge i_clk) disable iff (clr)
		rd_go && rd_addr == `ACC_A_ERR |=> tx_r[4:2] == {2'b00, $past(conf_bad)})
		else $error("Fault code does not match configuration.");
endmodule : acc_register_bank

// ===== acc_host_model.sv
// Host controller model driving the bank's four-wire serial port, mode 0.
// Assumes the testbench calls frame() and then reads the bytes left in rx.
module acc_host_model (
	input  wire logic i_miso,
	input  wire logic i_miso_oe,
	output logic      o_sck,
	output logic      o_cs_b,
	output logic      o_mosi
);
	timeunit 1ns;
	timeprecision 1ps;

	localparam int HALF = 400;

	logic [7:0] rx [8];

	initial
	begin
		o_sck  = 1'b0;
		o_cs_b = 1'b1;
		o_mosi = 1'b0;
	end

	// A bit is taken just before each fall, where the device holds it steady.
	// An undriven line reads as unknown so that it can never match.
	task automatic shift_byte(input logic [7:0] tx, output logic [7:0] got);
		for (int i = 7; i >= 0; i--)
		begin
			o_mosi = tx[i];
			#HALF o_sck = 1'b1;
			#HALF got[i] = i_miso_oe ? i_miso : 1'bx;
			o_sck = 1'b0;
		end
	endtask : shift_byte

	task automatic frame(input logic rd, input logic [6:0] addr,
		input int n, input logic [7:0] wd);
		logic [7:0] unused;
		#37 o_cs_b = 1'b0;
		#HALF shift_byte({rd, addr}, unused);
		for (int k = 0; k < n; k++)
			shift_byte(wd, rx[k]);
		#HALF o_cs_b = 1'b1;
		o_mosi = ~o_mosi;
		#(2 * HALF);
	endtask : frame
endmodule : acc_host_model

// ===== testbench.sv
// Self-checking bench for the accel register bank.
// Assumes the bank, its package and the host model are compiled first.
`define CHK(got, exp, msg) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) \
		begin \
			fail_count++; \
			$display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp); \
		end \
	end

module testbench
	import acc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] ID   = 8'h3c; // Arbitrary value.
	localparam int         TCYC = 100;
	localparam int         NR   = 20;

	typedef struct packed {
		logic       w;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} acc_row_t;

	logic        clk, rst_b, sck, cs_b, mosi, miso, miso_oe, sv, fatal;
	logic        p1, p1_oe, p2, p2_oe;
	logic [10:0] temp;
	logic [15:0] w;
	logic [7:0]  t0;
	acc_axes_t   smp;
	int          fail_count = 0;
	int          cmp_count  = 0;
	int          cyc        = 0;
	int          s;

	acc_row_t rows [NR] = '{
		{1'b0, 8'h00, 8'h00, ID}, {1'b1, 8'h00, 8'h77, ID},
		{1'b0, 8'h02, 8'h00, 8'h00}, {1'b0, 8'h03, 8'h00, 8'h10},
		{1'b0, 8'h01, 8'h00, 8'h00}, {1'b0, 8'h30, 8'h00, 8'h00},
		{1'b0, 8'h1d, 8'h00, 8'h00}, {1'b0, 8'h40, 8'h00, 8'ha8},
		{1'b0, 8'h7c, 8'h00, 8'h03}, {1'b1, 8'h41, 8'hff, 8'h03},
		{1'b1, 8'h53, 8'hff, 8'h1e}, {1'b1, 8'h54, 8'hff, 8'h1e},
		{1'b1, 8'h58, 8'hff, 8'h44}, {1'b1, 8'h6d, 8'h5a, 8'h5a},
		{1'b1, 8'h7c, 8'h00, 8'h00}, {1'b1, 8'h7d, 8'h04, 8'h04},
		{1'b0, 8'h22, 8'h00, 8'h9e}, {1'b0, 8'h23, 8'h00, 8'ha0},
		{1'b1, 8'h30, 8'h55, 8'h00}, {1'b0, 8'h12, 8'h00, 8'h00}
	};

	acc_host_model host (
		.i_miso    (miso),
		.i_miso_oe (miso_oe),
		.o_sck     (sck),
		.o_cs_b    (cs_b),
		.o_mosi    (mosi)
	);

	acc_register_bank #(
		.ID_CODE  (ID),
		.TEMP_CYC (TCYC)
	) dut (
		.i_clk            (clk),
		.i_rst_b          (rst_b),
		.i_spi_sck        (sck),
		.i_spi_cs_b       (cs_b),
		.i_spi_mosi       (mosi),
		.o_spi_miso       (miso),
		.o_spi_miso_oe    (miso_oe),
		.i_sample_valid   (sv),
		.i_sample         (smp),
		.i_temp_value     (temp),
		.i_fatal_fault    (fatal),
		.o_irq_pin_one    (p1),
		.o_irq_pin_one_oe (p1_oe),
		.o_irq_pin_two    (p2),
		.o_irq_pin_two_oe (p2_oe)
	);

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk)
		cyc <= cyc + 1;

	task automatic report_and_stop;
		$display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	task automatic rd(input logic [7:0] a, input int n);
		host.frame(1'b1, a[6:0], n, 8'h00);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.frame(1'b0, a[6:0], 1, d);
	endtask : wr

	task automatic pulse(input logic f, input acc_axes_t v);
		@(negedge clk);
		smp   = v;
		sv    = ~f;
		fatal = f;
		@(negedge clk);
		sv    = 1'b0;
		fatal = 1'b0;
	endtask : pulse

	task automatic hw_reset;
		@(negedge clk);
		rst_b = 1'b0;
		repeat (5) @(negedge clk);
		`CHK({miso_oe, p1_oe, p2_oe}, 3'b000, "reset outs")
		rst_b = 1'b1;
		repeat (5) @(negedge clk);
	endtask : hw_reset

	initial
	begin
		#5_000_000;
		fail_count++;
		report_and_stop();
	end

	initial
	begin
		rst_b = 1'b0;
		sv    = 1'b0;
		fatal = 1'b0;
		smp   = '0;
		temp  = 11'h4f5;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		repeat (5) @(negedge clk);
		for (int r = 0; r < NR; r++)
		begin
			if (rows[r].w)
				wr(rows[r].a, rows[r].d);
			rd(rows[r].a, 1);
			`CHK(host.rx[0], rows[r].e, "map row")
		end
		$display("test register map done");

		wr(8'h53, 8'h0a);
		wr(8'h54, 8'h08);
		`CHK({p1, p1_oe, p2, p2_oe}, 4'b0111, "pins idle")
		pulse(1'b0, 48'h8123_fe01_7f80);
		repeat (2) @(negedge clk);
		`CHK({p1, p1_oe, p2, p2_oe}, 4'b1101, "pins active")
		rd(8'h03, 1);
		`CHK(host.rx[0], 8'h90, "ready set")
		rd(8'h1d, 1);
		`CHK(host.rx[0], 8'h80, "irq set")
		rd(8'h1d, 1);
		`CHK(host.rx[0], 8'h00, "irq clear")
		`CHK({p1, p1_oe, p2, p2_oe}, 4'b0111, "pins idle")
		rd(8'h12, 6);
		for (int k = 0; k < 3; k++)
		begin
			w = smp[47 - 16 * k -: 16];
			`CHK({host.rx[2 * k + 1], host.rx[2 * k]}, w, "axis")
		end
		rd(8'h03, 1);
		`CHK(host.rx[0], 8'h10, "ready clear")
		rd(8'h11, 1);
		pulse(1'b0, 48'h1234_0000_0000);
		rd(8'h13, 1);
		`CHK(host.rx[0], 8'h81, "frozen high")
		rd(8'h13, 1);
		`CHK(host.rx[0], 8'h12, "fresh high")
		wr(8'h53, 8'h0e);
		`CHK({p1, p1_oe, p2, p2_oe}, 4'b1001, "open drain off")
		rd(8'h1d, 1);
		`CHK({p1, p1_oe, p2, p2_oe}, 4'b0111, "open drain low")
		$display("test sample path done");

		// Two reads exactly 6250 cycles apart must differ by 16 ticks.
		@(negedge clk);
		s = cyc;
		rd(8'h18, 1);
		t0 = host.rx[0];
		while (cyc != s + 6250)
			@(negedge clk);
		rd(8'h18, 1);
		`CHK(host.rx[0], t0 + 8'h10, "time ticks")
		temp = 11'h406;
		repeat (TCYC + 2) @(negedge clk);
		rd(8'h22, 2);
		`CHK({host.rx[0], host.rx[1]}, 16'h80c0, "temperature")
		$display("test time and temperature done");

		wr(8'h40, 8'h17);
		rd(8'h02, 1);
		`CHK(host.rx[0], 8'h04, "config fault")
		pulse(1'b1, '0);
		wr(8'h40, 8'ha8);
		rd(8'h02, 1);
		`CHK(host.rx[0], 8'h01, "fatal sticky")
		wr(8'h7e, 8'hb5);
		rd(8'h02, 1);
		`CHK(host.rx[0], 8'h01, "near command")
		wr(8'h7e, 8'hb6);
		rd(8'h02, 1);
		`CHK(host.rx[0], 8'h00, "soft reset")
		rd(8'h41, 1);
		`CHK(host.rx[0], 8'h01, "range default")
		rd(8'h03, 1);
		`CHK(host.rx[0], 8'h10, "status default")
		$display("test faults and soft reset done");

		wr(8'h6d, 8'h5a);
		hw_reset();
		rd(8'h6d, 1);
		`CHK(host.rx[0], 8'h00, "hard reset")
		$display("test hard reset done");
		report_and_stop();
	end
endmodule : testbench
